// ==== design/cbt_pkg.sv ====
// Shared constants and types of the CAN bit-timing and page-select block.
package cbt_pkg;

  // Special function register addresses.
  localparam logic [7:0] ADDR_PAGE = 8'hb1; // Message object page.
  localparam logic [7:0] ADDR_BT1  = 8'hb4; // Prescaler field.
  localparam logic [7:0] ADDR_BT2  = 8'hb5; // Jump width and propagation.
  localparam logic [7:0] ADDR_BT3  = 8'hb6; // Phase segments and sampling.
  localparam logic [7:0] ADDR_MSG  = 8'hb7; // Data byte window.

  // Writable bit masks; reserved bits are never stored.
  localparam logic [7:0] MASK_BT1 = 8'h7e;
  localparam logic [7:0] MASK_BT2 = 8'h6e;
  localparam logic [7:0] MASK_BT3 = 8'h7f;

  // Field positions.
  localparam int PRESC_LSB  = 1; // Prescaler, six bits.
  localparam int JUMP_LSB   = 5; // Jump width, two bits.
  localparam int PROP_LSB   = 1; // Propagation segment, three bits.
  localparam int PH2_LSB    = 4; // Phase segment two, three bits.
  localparam int PH1_LSB    = 1; // Phase segment one, three bits.
  localparam int TRIPLE_BIT = 0; // Triple sample select.
  localparam int OBJ_LSB    = 4; // Object select, four bits.
  localparam int HOLD_BIT   = 3; // Index hold, active low increment.
  localparam int IDX_LSB    = 0; // Data byte index, three bits.

  // Reset value of the page register.
  localparam logic [7:0] PAGE_RST = 8'h00;

  // Message object geometry.
  localparam int NUM_OBJ       = 15;
  localparam int BYTES_PER_OBJ = 8;

  // Bit timing sequencer states.
  typedef enum logic [2:0] {
    CBT_IDLE = 3'b000,
    CBT_SYNC = 3'b001,
    CBT_PROP = 3'b010,
    CBT_PH1  = 3'b011,
    CBT_PH2  = 3'b100
  } cbt_state_t;

endpackage

// ==== design/cbt_mem.sv ====
// Message object data storage with a registered read port.
`timescale 1ns/1ns
module cbt_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 120,
  parameter int AW    = 7
) (
  // Clock and freeze.
  input  wire logic             mclk,
  input  wire logic             ce,
  // Access port.
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata_q
);

  // Storage array; contents are undefined until software writes them.
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write and registered read; out-of-range addresses are never issued.
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (wr_en) begin
        mem_q[addr] <= wdata;
      end
      if (rd_en) begin
        rdata_q <= mem_q[addr];
      end
    end
  end

endmodule

// ==== design/cbt_top.sv ====
// CAN bit timing sequencer, timing registers and message object page.
//
// Summary of operation
// - Time quantum is prescaler plus one clocks.
// - Resynchronise on relevant recessive-to-dominant edges.
// - Each adjustment limited to jump width plus one.
// - Propagation segment is field plus one quanta.
// - Phase two is field plus one, shortenable.
// - Phase one is field plus one, lengthenable.
// - Reserved bits read undefined, never written one.
// - Timing registers have no reset value.
// - Object select picks message object zero..fourteen.
// - Index hold low advances index after access.
// - Index picks byte of object data field.
`timescale 1ns/1ns
module cbt_top
  import cbt_pkg::*;
#(
  parameter int NUM_OBJS  = cbt_pkg::NUM_OBJ,
  parameter int OBJ_BYTES = cbt_pkg::BYTES_PER_OBJ
) (
  // Clock, reset and freeze.
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Special function register access.
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata_q,
  output logic            sfr_rvalid_q,
  // Global enable of the controller.
  input  wire logic       can_enable,
  // Bus receive pin.
  input  wire logic       can_rx,
  // Bit timing results.
  output logic            bit_start_q,
  output logic            sample_strobe_q,
  output logic            sample_bit_q,
  // Page selection towards the message object logic.
  output logic      [3:0] object_select_q,
  output logic      [2:0] data_byte_index_q
);

  localparam int DEPTH = NUM_OBJS * OBJ_BYTES;

  // Timing registers, deliberately without reset.
  logic [7:0] bt1_q, bt2_q, bt3_q;
  logic [7:0] bt1_d, bt2_d, bt3_d;
  // Page register and read pipeline.
  logic [7:0] page_q, page_d;
  logic       rd_p1_q, rd_p1_d;     // Read accepted one cycle ago.
  logic       rd_msg_q, rd_msg_d;   // That read was a data byte.
  logic [7:0] rd_reg_q, rd_reg_d;   // Captured non-memory value.
  logic [7:0] rdata_d;
  logic       rvalid_d;
  logic [7:0] mem_rdata;            // Registered memory output.
  // Field views.
  logic [5:0] baud_prescaler;
  logic [1:0] resync_jump_width;
  logic [2:0] propagation_segment, phase_segment_one, phase_segment_two;
  logic       triple_sample_select;
  logic [3:0] obj;
  logic [2:0] idx;
  logic       msg_acc, obj_ok;

  assign baud_prescaler       = bt1_q[PRESC_LSB +: 6];
  assign resync_jump_width    = bt2_q[JUMP_LSB +: 2];
  assign propagation_segment  = bt2_q[PROP_LSB +: 3];
  assign phase_segment_two    = bt3_q[PH2_LSB +: 3];
  assign phase_segment_one    = bt3_q[PH1_LSB +: 3];
  assign triple_sample_select = bt3_q[TRIPLE_BIT];
  assign obj  = page_q[OBJ_LSB +: 4];
  assign idx  = page_q[IDX_LSB +: 3];
  // Object fifteen does not exist, so its data window is dead.
  assign obj_ok  = (obj < 4'(NUM_OBJS));
  assign msg_acc = (sfr_rd || sfr_wr) && (sfr_addr == ADDR_MSG);

  // Majority of three samples.
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Register file next values: writes, index advance and read capture.
  always_comb begin
    bt1_d    = bt1_q;
    bt2_d    = bt2_q;
    bt3_d    = bt3_q;
    page_d   = page_q;
    rd_p1_d  = sfr_rd;
    rd_msg_d = sfr_rd && (sfr_addr == ADDR_MSG) && obj_ok;
    rd_reg_d = 8'h00;
    if (sfr_wr) begin
      // Reserved bits are masked off so they can never be set.
      case (sfr_addr)
        ADDR_PAGE: page_d = sfr_wdata;
        ADDR_BT1:  bt1_d  = sfr_wdata & MASK_BT1;
        ADDR_BT2:  bt2_d  = sfr_wdata & MASK_BT2;
        ADDR_BT3:  bt3_d  = sfr_wdata & MASK_BT3;
        default:   page_d = page_q;
      endcase
    end
    // The index advances after every data access unless held.
    if (msg_acc && !page_q[HOLD_BIT]) begin
      page_d[IDX_LSB +: 3] = idx + 3'h1;
    end
    // Reserved bits read as zero, one legal choice of undefined.
    case (sfr_addr)
      ADDR_PAGE: rd_reg_d = page_q;
      ADDR_BT1:  rd_reg_d = bt1_q & MASK_BT1;
      ADDR_BT2:  rd_reg_d = bt2_q & MASK_BT2;
      ADDR_BT3:  rd_reg_d = bt3_q & MASK_BT3;
      default:   rd_reg_d = 8'h00;
    endcase
    rvalid_d = rd_p1_q;
    // The read data only change with a new answer and hold otherwise.
    rdata_d  = rd_p1_q ? (rd_msg_q ? mem_rdata : rd_reg_q) : sfr_rdata_q;
  end

  // Timing registers keep whatever they power up with.
  always_ff @(posedge mclk) begin
    if (ce) begin
      bt1_q <= bt1_d;
      bt2_q <= bt2_d;
      bt3_q <= bt3_d;
    end
  end

  // Page register and read pipeline with reset.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      page_q            <= PAGE_RST;
      rd_p1_q           <= 1'b0;
      rd_msg_q          <= 1'b0;
      rd_reg_q          <= 8'h00;
      sfr_rdata_q       <= 8'h00;
      sfr_rvalid_q      <= 1'b0;
      object_select_q   <= 4'h0;
      data_byte_index_q <= 3'h0;
    end else if (ce) begin
      page_q            <= page_d;
      rd_p1_q           <= rd_p1_d;
      rd_msg_q          <= rd_msg_d;
      rd_reg_q          <= rd_reg_d;
      sfr_rdata_q       <= rdata_d;
      sfr_rvalid_q      <= rvalid_d;
      object_select_q   <= page_d[OBJ_LSB +: 4];
      data_byte_index_q <= page_d[IDX_LSB +: 3];
    end
  end

  // Byte storage addressed by object and index.
  cbt_mem #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (7)
  ) u_mem (
    .mclk    (mclk),
    .ce      (ce),
    .wr_en   (sfr_wr && (sfr_addr == ADDR_MSG) && obj_ok),
    .rd_en   (sfr_rd && (sfr_addr == ADDR_MSG) && obj_ok),
    .addr    ({obj, idx}),
    .wdata   (sfr_wdata),
    .rdata_q (mem_rdata)
  );

  // Bit timing sequencer state.
  cbt_state_t st_q, st_d;
  logic [5:0] presc_q, presc_d;     // Clock count inside a quantum.
  logic [3:0] seg_q, seg_d;         // Quantum count inside a segment.
  logic [2:0] ext_q, ext_d;         // Phase one lengthening.
  logic       done_q, done_d;       // One resync per bit already used.
  logic [2:0] hist_q, hist_d;       // Rx seen at the last quanta.
  logic       last_q, last_d;       // Last sampled bit value.
  logic       rx_m_q, rx_s_q, rx_p_q;
  logic       tick, edge_ok, bs_d, ss_d, sb_d;
  logic [4:0] err;                  // Phase error in quanta.
  logic [3:0] rem;                  // Quanta left in phase two.
  logic [2:0] jw;                   // Jump width in quanta.

  // Pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge mclk) begin
    if (ce) begin
      rx_m_q <= can_rx;
      rx_s_q <= rx_m_q;
      rx_p_q <= rx_s_q;
    end
  end

  assign tick = (presc_q == baud_prescaler);
  assign jw   = {1'b0, resync_jump_width} + 3'h1;
  // Only a falling edge after a recessive bit counts, once per bit.
  assign edge_ok = rx_p_q && !rx_s_q && last_q && !done_q;
  assign rem  = {1'b0, phase_segment_two} - seg_q;

  // Sequencer next values.
  always_comb begin
    st_d    = st_q;
    presc_d = tick ? 6'h00 : presc_q + 6'h01;
    seg_d   = seg_q;
    ext_d   = ext_q;
    done_d  = done_q;
    hist_d  = tick ? {hist_q[1:0], rx_s_q} : hist_q;
    last_d  = last_q;
    bs_d    = 1'b0;
    ss_d    = 1'b0;
    sb_d    = sample_bit_q;
    err     = 5'h00;
    case (st_q)
      CBT_PROP: err = 5'(seg_q) + 5'h01;
      CBT_PH1:  err = 5'(propagation_segment) + 5'(seg_q) + 5'h02;
      default:  err = 5'h00;
    endcase
    if (!can_enable) begin
      st_d    = CBT_IDLE;
      presc_d = 6'h00;
      last_d  = 1'b1;
      done_d  = 1'b0;
    end else if (edge_ok && (st_q == CBT_PROP || st_q == CBT_PH1)) begin
      // Late edge: stretch phase one by the error, capped.
      ext_d  = (err > 5'(jw)) ? jw : err[2:0];
      done_d = 1'b1;
      // The quantum tick must still end the propagation segment, or the
      // count would run past its end and never leave this state.
      if (tick && st_q == CBT_PROP
          && seg_q == 4'(propagation_segment)) begin
        st_d  = CBT_PH1;
        seg_d = 4'h0;
      end else if (tick) begin
        seg_d = seg_q + 4'h1;
      end
    end else if (edge_ok && st_q == CBT_PH2) begin
      done_d = 1'b1;
      if (rem < 4'(jw)) begin
        // Early edge close enough: the edge becomes the sync quantum.
        st_d    = CBT_PROP;
        seg_d   = 4'h0;
        presc_d = 6'h00;
        bs_d    = 1'b1;
      end else begin
        seg_d = seg_q + 4'(jw);
      end
    end else if (tick) begin
      case (st_q)
        CBT_IDLE: begin
          st_d = CBT_SYNC;
        end
        CBT_SYNC: begin
          st_d  = CBT_PROP;
          seg_d = 4'h0;
        end
        CBT_PROP: begin
          if (seg_q == 4'(propagation_segment)) begin
            st_d  = CBT_PH1;
            seg_d = 4'h0;
          end else begin
            seg_d = seg_q + 4'h1;
          end
        end
        CBT_PH1: begin
          if (seg_q == 4'(phase_segment_one) + 4'(ext_q)) begin
            st_d   = CBT_PH2;
            seg_d  = 4'h0;
            ext_d  = 3'h0;
            done_d = 1'b0;
            ss_d   = 1'b1;
            sb_d   = triple_sample_select
              ? maj3({hist_q[1:0], rx_s_q}) : rx_s_q;
            last_d = sb_d;
          end else begin
            seg_d = seg_q + 4'h1;
          end
        end
        CBT_PH2: begin
          if (seg_q >= 4'(phase_segment_two)) begin
            st_d = CBT_SYNC;
            bs_d = 1'b1;
          end else begin
            seg_d = seg_q + 4'h1;
          end
        end
        default: st_d = CBT_IDLE;
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q            <= CBT_IDLE;
      presc_q         <= 6'h00;
      seg_q           <= 4'h0;
      ext_q           <= 3'h0;
      done_q          <= 1'b0;
      hist_q          <= 3'h7;
      last_q          <= 1'b1;
      bit_start_q     <= 1'b0;
      sample_strobe_q <= 1'b0;
      sample_bit_q    <= 1'b1;
    end else if (ce) begin
      st_q            <= st_d;
      presc_q         <= presc_d;
      seg_q           <= seg_d;
      ext_q           <= ext_d;
      done_q          <= done_d;
      hist_q          <= hist_d;
      last_q          <= last_d;
      bit_start_q     <= bs_d;
      sample_strobe_q <= ss_d;
      sample_bit_q    <= sb_d;
    end
  end

  // Checks on the running logic.
  quantum_len_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && can_enable && !tick && !(edge_ok && st_q == CBT_PH2
      && rem < 4'(jw)) |=> (presc_q == $past(presc_q) + 6'h01)
      || !$past(ce))
    else $error("prescaler skipped a count");
  jump_cap_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_q == CBT_PH1 |-> ext_q <= jw)
    else $error("phase one stretched beyond jump width");
  prop_len_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && can_enable && tick && st_q == CBT_PROP
      && seg_q == 4'(propagation_segment)
      |=> st_q == CBT_PH1 && seg_q == 4'h0)
    else $error("propagation segment length wrong");
  early_edge_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && can_enable && edge_ok && st_q == CBT_PH2 && rem < 4'(jw)
      |=> st_q == CBT_PROP && bit_start_q)
    else $error("early edge did not restart the bit");
  ph1_bound_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_q == CBT_PH1 |-> seg_q <= 4'(phase_segment_one) + 4'(ext_q))
    else $error("phase one overran");
  single_sample_a: assert property (@(posedge mclk)
    disable iff (!resetn)
    ce && $past(ce) && sample_strobe_q && !triple_sample_select
      |-> sample_bit_q == $past(rx_s_q))
    else $error("single sample mismatch");
  page_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && sfr_wr && sfr_addr == ADDR_PAGE |=> page_q == $past(sfr_wdata))
    else $error("page write lost");
  index_step_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && msg_acc |=> idx == ($past(page_q[HOLD_BIT]) ? $past(idx)
      : $past(idx) + 3'h1))
    else $error("index advance wrong");
  read_latency_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && sfr_rd ##1 ce ##1 ce |-> sfr_rvalid_q)
    else $error("read answer late");

endmodule

// ==== verif/cbt_bus_node.sv ====
// Model of another node that drives the block's receive line.
`timescale 1ns/1ns
module cbt_bus_node (
  // Clock used to time the driven levels.
  input  wire logic mclk,
  // Receive line seen by the block.
  output logic      can_rx
);
  // The bus idles recessive through its termination.
  initial begin
    can_rx = 1'b1;
  end

  // Drive a level for some clocks, then release to the recessive level.
  // Released means recessive here, since the bus has a pull to that level.
  task automatic drive(input logic lvl, input int cycles);
    can_rx <= lvl;
    repeat (cycles) @(posedge mclk);
    can_rx <= 1'b1;
  endtask
endmodule

// ==== verif/cbt_top_test.sv ====
// Self-checking bench for the bit timing and page select block.
`timescale 1ns/1ns
module cbt_top_test;
  import cbt_pkg::*;

  logic       mclk;        // Clock, 4 ns period.
  logic       resetn;      // Synchronous reset, active low.
  logic       ce;          // Clock enable.
  logic       sfr_wr;      // Register write strobe.
  logic       sfr_rd;      // Register read strobe.
  logic [7:0] sfr_addr;    // Register address.
  logic [7:0] sfr_wdata;   // Register write data.
  logic [7:0] sfr_rdata_q; // Register read data.
  logic       sfr_rvalid_q;
  logic       can_enable;  // Global controller enable.
  logic       can_rx;      // Receive line from the node model.
  logic       bit_start_q;
  logic       sample_strobe_q;
  logic       sample_bit_q;
  logic [3:0] object_select_q;
  logic [2:0] data_byte_index_q;
  int         mismatches;  // Failed comparisons.
  int         cmp_count;   // All comparisons.
  logic [7:0] d;           // Last read value.
  int         n;           // Last measured distance in clocks.

  // Clock generator.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // The clock enable stays high except where a scenario freezes the block.
  cbt_top dut (.mclk(mclk), .resetn(resetn), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .sfr_rvalid_q(sfr_rvalid_q), .can_enable(can_enable),
    .can_rx(can_rx), .bit_start_q(bit_start_q),
    .sample_strobe_q(sample_strobe_q), .sample_bit_q(sample_bit_q),
    .object_select_q(object_select_q),
    .data_byte_index_q(data_byte_index_q));

  // Far side node on the receive line.
  cbt_bus_node node (.mclk(mclk), .can_rx(can_rx));

  // Print the counts and the verdict, then stop.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compare two bytes with case equality so unknowns never match.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write cycle; the strobe drops at the same edge that takes it, and the
  // task returns one edge later so that the new state is already visible.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
    @(posedge mclk);
  endtask

  // One read cycle; the answer is awaited under a bound.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    int k;
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    k = 0;
    while (sfr_rvalid_q !== 1'b1 && k < 8) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 8) begin
      mismatches++;
      summarize();
    end
    v = sfr_rdata_q;
  endtask

  // Count clocks to the next pulse of the chosen timing output.
  task automatic wait_pulse(input bit strobe, output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while ((strobe ? sample_strobe_q : bit_start_q) !== 1'b1 && c < 200);
    if (c >= 200) begin
      mismatches++;
      summarize();
    end
  endtask

  // Page register and outputs after reset.
  task automatic test_reset();
    rd(ADDR_PAGE, d);
    check(d, 8'h00);
    check({4'h0, object_select_q}, 8'h00);
    check({5'h00, data_byte_index_q}, 8'h00);
    // A write taken while the block is frozen must be lost.
    ce <= 1'b0;
    wr(ADDR_PAGE, 8'h21);
    ce <= 1'b1;
    check({4'h0, object_select_q}, 8'h00);
  endtask

  // Reserved timing bits are not stored; unmapped reads give zero.
  task automatic test_masks();
    wr(ADDR_BT2, 8'hff);
    wr(ADDR_BT3, 8'hff);
    rd(ADDR_BT2, d);
    check(d, 8'h6e);
    rd(ADDR_BT3, d);
    check(d, 8'h7f);
    rd(8'hc0, d);
    check(d, 8'h00);
  endtask

  // Object select, byte index, auto-increment, wrap and hold.
  task automatic test_page();
    wr(ADDR_PAGE, 8'h56);
    check({4'h0, object_select_q}, 8'h05);
    check({5'h00, data_byte_index_q}, 8'h06);
    wr(ADDR_MSG, 8'ha6);
    check({5'h00, data_byte_index_q}, 8'h07);
    wr(ADDR_MSG, 8'ha7);
    check({5'h00, data_byte_index_q}, 8'h00);
    wr(ADDR_PAGE, 8'he6);
    wr(ADDR_MSG, 8'h3c);
    wr(ADDR_PAGE, 8'h5e);
    rd(ADDR_MSG, d);
    check(d, 8'ha6);
    check({5'h00, data_byte_index_q}, 8'h06);
    wr(ADDR_PAGE, 8'he6);
    rd(ADDR_MSG, d);
    check(d, 8'h3c);
    check({5'h00, data_byte_index_q}, 8'h07);
    // Byte zero of object six must not alias byte seven of object five.
    wr(ADDR_PAGE, 8'h68);
    wr(ADDR_MSG, 8'h60);
    wr(ADDR_PAGE, 8'h5f);
    rd(ADDR_MSG, d);
    check(d, 8'ha7);
    // Object fifteen has no data, yet its index still advances.
    wr(ADDR_PAGE, 8'hf0);
    rd(ADDR_MSG, d);
    check(d, 8'h00);
    check({5'h00, data_byte_index_q}, 8'h01);
  endtask

  // Quantum of two clocks; bit of 1+2+3+2 quanta, 16 clocks.
  task automatic test_timing();
    wr(ADDR_BT1, 8'h02);
    wr(ADDR_BT2, 8'h02);
    wr(ADDR_BT3, 8'h15);
    @(posedge mclk);
    can_enable <= 1'b1;
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    check(8'(n), 8'h10);
    wait_pulse(1'b1, n);
    wait_pulse(1'b0, n);
    check(8'(n), 8'h04);
  endtask

  // A dominant run: one jump of at most one quantum, then majority 0.
  task automatic test_sample();
    wait_pulse(1'b0, n);
    fork
      node.drive(1'b0, 48);
    join_none
    wait_pulse(1'b0, n);
    check(8'(n >= 16 && n <= 18), 8'h01);
    wait_pulse(1'b1, n);
    @(posedge mclk);
    check({7'h00, sample_bit_q}, 8'h00);
    repeat (3) wait_pulse(1'b1, n);
    @(posedge mclk);
    check({7'h00, sample_bit_q}, 8'h01);
  endtask

  // Single sampling; an edge in the last quantum of phase two restarts
  // the bit, so the next bit is one jump width (one quantum) shorter.
  task automatic test_early();
    @(posedge mclk);
    can_enable <= 1'b0;
    wr(ADDR_BT3, 8'h14);
    can_enable <= 1'b1;
    wait_pulse(1'b1, n);
    fork
      node.drive(1'b0, 40);
    join_none
    wait_pulse(1'b0, n);
    check(8'(n), 8'h04);
    wait_pulse(1'b0, n);
    check(8'(n), 8'h0e);
    check({7'h00, sample_bit_q}, 8'h00);
  endtask

  // Main sequence: reset for five clocks, then each scenario.
  initial begin
    mismatches = 0;
    cmp_count  = 0;
    resetn     = 1'b0;
    ce         = 1'b1;
    sfr_wr     = 1'b0;
    sfr_rd     = 1'b0;
    sfr_addr   = 8'h00;
    sfr_wdata  = 8'h00;
    can_enable = 1'b0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    test_reset();
    test_masks();
    test_page();
    test_timing();
    test_sample();
    test_early();
    summarize();
  end
endmodule
